// [slbt_pkg.sv]
// Shared constants and carrier types of the lane bit error tester.
// Assumes one 10-bit symbol per lane per sys_clk cycle on both paths.
`default_nettype none
package slbt_pkg;

	localparam int LANES = 4;
	localparam int SYM_W = 10;
	localparam int CNT_W = 15;
	localparam int PRE_W = 7;

	// Generator mode codes
	localparam logic [2:0] GEN_OFF    = 3'h0;
	localparam logic [2:0] GEN_PRBS15 = 3'h1;
	localparam logic [2:0] GEN_PRBS7  = 3'h2;
	localparam logic [2:0] GEN_FIX    = 3'h3;
	localparam logic [2:0] GEN_ALT    = 3'h4;
	localparam logic [2:0] GEN_QUAD   = 3'h5;

	// Matcher mode codes
	localparam logic [2:0] PM_MODE_OFF    = 3'h0;
	localparam logic [2:0] PM_MODE_PRBS15 = 3'h1;
	localparam logic [2:0] PM_MODE_PRBS7  = 3'h2;
	localparam logic [2:0] PM_MODE_SAME   = 3'h3;
	localparam logic [2:0] PM_MODE_INV    = 3'h4;

	// Fixed symbols of the four-symbol pattern
	localparam logic [9:0] SYM_ZEROS = 10'h000;
	localparam logic [9:0] SYM_ONES  = 10'h3FF;

	// Reset values
	localparam logic [14:0] LFSR_SEED = 15'h7FFF;
	localparam logic [9:0]  RST_SYM   = 10'h000;

	// Matcher sync: good symbols to lock, bad symbols to drop lock
	localparam logic [3:0] SYNC_GOOD = 4'h8;
	localparam logic [3:0] LOSS_BAD  = 4'h4;

	// Comma prefixes of both disparities, first seven bits on the wire
	localparam logic [6:0] COMMA_P = 7'h1F;
	localparam logic [6:0] COMMA_N = 7'h60;

	// Error counter limits; 32768 errors equal 256 units of 128
	localparam logic [14:0] CNT_MAX     = 15'h7FFF;
	localparam logic [14:0] CNT_RESCALE = 15'h0100;
	localparam logic [6:0]  PRE_MAX     = 7'h7F;

	typedef enum logic [2:0] {
		PM_OFF  = 3'h1,
		PM_HUNT = 3'h2,
		PM_LOCK = 3'h4
	} slbt_pm_state_e;

	typedef struct packed {
		logic [2:0] gen_mode;
		logic [2:0] pm_mode;
		logic [9:0] fixed_pattern_value;
		logic       rx_align_en;
	} slbt_lane_cfg_s;

	typedef struct packed {
		logic [14:0] count;
		logic        error_count_scaled_flag;
	} slbt_err_s;

endpackage
`default_nettype wire

// [slbt_err_counter.sv]
// Scaled error counter of one lane with a pipelined read snapshot.
// Assumes clear, err_pulse and rd_strobe are one-cycle synchronous pulses.
`timescale 1ns/10ps
`default_nettype none
module slbt_err_counter
(
	input  wire logic              sys_clk,   // system clock
	input  wire logic              rstn,      // async reset, active low
	input  wire logic              clear,     // zero all count state
	input  wire logic              err_pulse, // one erroneous symbol
	input  wire logic              rd_strobe, // read of the count
	output var  slbt_pkg::slbt_err_s report   // value seen by the reader
);

	typedef struct packed {
		logic [6:0]          pre;
		slbt_pkg::slbt_err_s live;
		slbt_pkg::slbt_err_s snap;
		slbt_pkg::slbt_err_s outv;
	} slbt_cnt_st_s;

	slbt_cnt_st_s st_q;
	slbt_cnt_st_s st_d;

	always_comb
	begin
		st_d = st_q;
		if (clear)
		begin
			st_d = '0;
		end
		if (rd_strobe && !clear)
		begin
			st_d.outv = st_q.snap;
			st_d.snap = st_q.live;
		end
		// Count with scaling
		// Applied after the clear so an error in the clear cycle survives
		if (err_pulse)
		begin
			if (!st_d.live.error_count_scaled_flag)
			begin
				if (st_d.live.count == slbt_pkg::CNT_MAX)
				begin
					st_d.live.error_count_scaled_flag = 1'b1;
					st_d.live.count = slbt_pkg::CNT_RESCALE;
					st_d.pre = '0;
				end
				else
				begin
					st_d.live.count = st_d.live.count + 15'h0001;
				end
			end
			else if (st_d.live.count != slbt_pkg::CNT_MAX)
			begin
				if (st_d.pre == slbt_pkg::PRE_MAX)
				begin
					st_d.pre = '0;
					st_d.live.count = st_d.live.count + 15'h0001;
				end
				else
				begin
					st_d.pre = st_d.pre + 7'h01;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign report = st_q.outv;

endmodule
`default_nettype wire

// [slbt_bert_port.sv]
// Bit error test logic of one four-lane serial port: per-lane pattern
// generators, receive word aligners, pattern matchers and counters.
// Assumes one parallel 10-bit symbol per lane per cycle, bit 9 first on
// the wire, and all control inputs synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module slbt_bert_port
(
	input  wire logic                   sys_clk,    // system clock
	input  wire logic                   rstn,       // async reset, low
	input  wire slbt_pkg::slbt_lane_cfg_s [3:0] lane_cfg, // lane setup
	input  wire logic [3:0][9:0]        tx_traffic, // normal tx symbols
	input  wire logic [3:0][9:0]        rx_symbol,  // raw rx symbols
	input  wire logic [3:0]             cnt_clear,  // clear counter
	input  wire logic [3:0]             cnt_read,   // read counter
	output var  logic [3:0][9:0]        tx_symbol,  // symbols to send
	output var  logic [3:0][9:0]        rx_word,    // received symbols
	output var  logic [3:0]             pm_synced,  // matcher locked
	output var  slbt_pkg::slbt_err_s [3:0] err_report // count per lane
);

	typedef struct packed {
		logic [2:0]               gen_mode_prev;
		logic [1:0]               fix_idx;
		logic [14:0]              tx_lfsr;
		logic [9:0]               tx_sym;
		logic [9:0]               rx_prev;
		logic [9:0]               rx_cur;
		logic [3:0]               align_off;
		logic [9:0]               word;
		logic [9:0]               word_prev;
		slbt_pkg::slbt_pm_state_e pm_st;
		logic [2:0]               pm_mode_prev;
		logic [14:0]              pm_lfsr;
		logic [9:0]               pm_pred;
		logic [3:0]               run_cnt;
		logic                     err;
	} slbt_lane_st_s;

	slbt_lane_st_s [3:0] st_q;
	slbt_lane_st_s [3:0] st_d;

	// Runs the PRBS ten steps; returns {next state, symbol}, bit 9 first
	function automatic logic [24:0] prbs_step
	(
		input logic [14:0] s_in,
		input logic        long_poly
	);
		logic [14:0] s;
		logic [9:0]  sym;
		logic        fb;
		s = s_in;
		sym = '0;
		fb = 1'b0;
		for (int b = 9; b >= 0; b--)
		begin
			fb = long_poly ? (s[14] ^ s[13]) : (s[6] ^ s[5]);
			sym[b] = fb;
			s = {s[13:0], fb};
		end
		return {s, sym};
	endfunction

	// Ten bits of the two-symbol history starting off bits from the top
	function automatic logic [9:0] window
	(
		input logic [19:0] h,
		input logic [3:0]  off
	);
		logic [19:0] t;
		t = h >> (4'hA - off);
		return t[9:0];
	endfunction

	always_comb
	begin
		logic [24:0] pr;
		logic [9:0]  pat;
		logic [2:0]  gm;
		logic [2:0]  pm;
		logic [1:0]  idx;
		logic        restart;
		logic [19:0] hist;
		logic        found;
		logic [3:0]  off;
		logic [9:0]  cand;
		logic        active;
		logic        lfsr_mode;
		logic        mism;
		logic [9:0]  pred;
		logic [14:0] base;
		pr = '0;
		pat = '0;
		gm = '0;
		pm = '0;
		idx = '0;
		restart = 1'b0;
		hist = '0;
		found = 1'b0;
		off = '0;
		cand = '0;
		active = 1'b0;
		lfsr_mode = 1'b0;
		mism = 1'b0;
		pred = '0;
		base = '0;
		st_d = st_q;
		for (int i = 0; i < slbt_pkg::LANES; i++)
		begin
			gm = lane_cfg[i].gen_mode;
			pm = lane_cfg[i].pm_mode;
			pat = lane_cfg[i].fixed_pattern_value;

			restart = (gm != st_q[i].gen_mode_prev);
			st_d[i].gen_mode_prev = gm;
			idx = restart ? 2'h0 : st_q[i].fix_idx;
			st_d[i].fix_idx = idx + 2'h1;
			case (gm)
				slbt_pkg::GEN_PRBS15,
				slbt_pkg::GEN_PRBS7:
				begin
					pr = prbs_step(restart ? slbt_pkg::LFSR_SEED
						: st_q[i].tx_lfsr,
						gm == slbt_pkg::GEN_PRBS15);
					st_d[i].tx_lfsr = pr[24:10];
					st_d[i].tx_sym = pr[9:0];
				end
				slbt_pkg::GEN_FIX:
				begin
					st_d[i].tx_sym = pat;
				end
				slbt_pkg::GEN_ALT:
				begin
					st_d[i].tx_sym = idx[0] ? ~pat : pat;
				end
				slbt_pkg::GEN_QUAD:
				begin
					case (idx)
						2'h0: st_d[i].tx_sym = slbt_pkg::SYM_ZEROS;
						2'h1: st_d[i].tx_sym = pat;
						2'h2: st_d[i].tx_sym = slbt_pkg::SYM_ONES;
						default: st_d[i].tx_sym = ~pat;
					endcase
				end
				default:
				begin
					st_d[i].tx_sym = tx_traffic[i];
				end
			endcase

			// Receive word alignment on the two-symbol history
			st_d[i].rx_prev = st_q[i].rx_cur;
			st_d[i].rx_cur = rx_symbol[i];
			hist = {st_q[i].rx_prev, st_q[i].rx_cur};
			found = 1'b0;
			off = st_q[i].align_off;
			for (int k = 0; k < 10; k++)
			begin
				cand = window(hist, 4'(k));
				if (!found && (cand[9:3] == slbt_pkg::COMMA_P
					|| cand[9:3] == slbt_pkg::COMMA_N))
				begin
					found = 1'b1;
					off = 4'(k);
				end
			end
			// Raw pass when off
			// Offset is kept while disabled so re-enabling resumes quickly
			if (lane_cfg[i].rx_align_en)
			begin
				st_d[i].align_off = off;
				st_d[i].word = window(hist, off);
			end
			else
			begin
				st_d[i].word = st_q[i].rx_cur;
			end
			st_d[i].word_prev = st_q[i].word;

			active = (pm == slbt_pkg::PM_MODE_PRBS15)
				|| (pm == slbt_pkg::PM_MODE_PRBS7)
				|| (pm == slbt_pkg::PM_MODE_SAME)
				|| (pm == slbt_pkg::PM_MODE_INV);
			lfsr_mode = (pm == slbt_pkg::PM_MODE_PRBS15)
				|| (pm == slbt_pkg::PM_MODE_PRBS7);
			st_d[i].pm_mode_prev = pm;

			pred = (pm == slbt_pkg::PM_MODE_INV) ? ~st_q[i].word_prev
				: st_q[i].word_prev;
			// Seed from stream
			// Hunting reseeds from the last 15 received bits each symbol
			base = (st_q[i].pm_st == slbt_pkg::PM_LOCK) ? st_q[i].pm_lfsr
				: {st_q[i].word_prev[4:0], st_q[i].word};
			pr = prbs_step(base, pm == slbt_pkg::PM_MODE_PRBS15);
			st_d[i].pm_lfsr = pr[24:10];
			st_d[i].pm_pred = pr[9:0];
			mism = lfsr_mode ? (st_q[i].word != st_q[i].pm_pred)
				: (st_q[i].word != pred);

			st_d[i].err = 1'b0;
			if (!active)
			begin
				st_d[i].pm_st = slbt_pkg::PM_OFF;
				st_d[i].run_cnt = '0;
			end
			else if (pm != st_q[i].pm_mode_prev)
			begin
				st_d[i].pm_st = slbt_pkg::PM_HUNT;
				st_d[i].run_cnt = '0;
			end
			else
			begin
				case (st_q[i].pm_st)
					slbt_pkg::PM_OFF:
					begin
						st_d[i].pm_st = slbt_pkg::PM_HUNT;
						st_d[i].run_cnt = '0;
					end
					slbt_pkg::PM_HUNT:
					begin
						if (mism)
						begin
							st_d[i].run_cnt = '0;
						end
						else if (st_q[i].run_cnt + 4'h1
							== slbt_pkg::SYNC_GOOD)
						begin
							st_d[i].pm_st = slbt_pkg::PM_LOCK;
							st_d[i].run_cnt = '0;
						end
						else
						begin
							st_d[i].run_cnt = st_q[i].run_cnt + 4'h1;
						end
					end
					slbt_pkg::PM_LOCK:
					begin
						st_d[i].err = mism;
						if (!mism)
						begin
							st_d[i].run_cnt = '0;
						end
						else if (st_q[i].run_cnt + 4'h1
							== slbt_pkg::LOSS_BAD)
						begin
							st_d[i].pm_st = slbt_pkg::PM_HUNT;
							st_d[i].run_cnt = '0;
						end
						else
						begin
							st_d[i].run_cnt = st_q[i].run_cnt + 4'h1;
						end
					end
					default:
					begin
						st_d[i].pm_st = slbt_pkg::PM_OFF;
						st_d[i].run_cnt = '0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_q <= '0;
			for (int i = 0; i < slbt_pkg::LANES; i++)
			begin
				st_q[i].pm_st <= slbt_pkg::PM_OFF;
				st_q[i].tx_lfsr <= slbt_pkg::LFSR_SEED;
				st_q[i].tx_sym <= slbt_pkg::RST_SYM;
			end
		end
		else
		begin
			st_q <= st_d;
		end
	end

	for (genvar g = 0; g < slbt_pkg::LANES; g++)
	begin : g_lane
		slbt_err_counter u_cnt
		(
			.sys_clk   (sys_clk),
			.rstn      (rstn),
			.clear     (cnt_clear[g]),
			.err_pulse (st_q[g].err),
			.rd_strobe (cnt_read[g]),
			.report    (err_report[g])
		);
	end

	always_comb
	begin
		for (int i = 0; i < slbt_pkg::LANES; i++)
		begin
			tx_symbol[i] = st_q[i].tx_sym;
			rx_word[i] = st_q[i].word;
			pm_synced[i] = st_q[i].pm_st[2];
		end
	end

endmodule
`default_nettype wire

// [slbt_bert_port_properties.sv]
// Checker of the lane tester port, watching lanes 0 and 1.
// Assumes it is bound onto slbt_bert_port.
`timescale 1ns/10ps
`default_nettype none
module slbt_bert_port_properties
(
	input wire logic                       sys_clk,    // clock
	input wire logic                       rstn,       // reset
	input wire slbt_pkg::slbt_lane_cfg_s [3:0] lane_cfg, // setup
	input wire logic [3:0][9:0]            tx_traffic, // traffic
	input wire logic [3:0][9:0]            rx_symbol,  // raw rx
	input wire logic [3:0]                 cnt_clear,  // clear
	input wire logic [3:0]                 cnt_read,   // read
	input wire logic [3:0][9:0]            tx_symbol,  // tx out
	input wire logic [3:0][9:0]            rx_word,    // rx out
	input wire logic [3:0]                 pm_synced,  // locked
	input wire slbt_pkg::slbt_err_s [3:0]  err_report  // counts
);
	logic [2:0] g0;
	logic [2:0] m0;
	logic [9:0] p0;
	logic       a0;
	assign g0 = lane_cfg[0].gen_mode;
	assign m0 = lane_cfg[0].pm_mode;
	assign p0 = lane_cfg[0].fixed_pattern_value;
	assign a0 = lane_cfg[0].rx_align_en;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	chk_off_traffic: assert property (
		$past(rstn) && ($past(g0) == 3'h0 || $past(g0) > 3'h5)
		|-> tx_symbol[0] == $past(tx_traffic[0]))
		else $error("traffic not sent with generator off");
	chk_lane_indep: assert property (
		$past(rstn) && $past(lane_cfg[1].gen_mode) == 3'h0
		|-> tx_symbol[1] == $past(tx_traffic[1]))
		else $error("lane 1 traffic disturbed");
	chk_fix_repeat: assert property (
		$past(rstn) && $past(g0) == 3'h3 |-> tx_symbol[0] == $past(p0))
		else $error("fixed pattern not sent");
	chk_alt_invert: assert property (
		$past(rstn) && $past(rstn, 2) && $past(g0) == 3'h4
		&& $past(g0, 2) == 3'h4 && $past(p0) == $past(p0, 2)
		|-> tx_symbol[0] == ~$past(tx_symbol[0]))
		else $error("alternate pattern not inverted");
	chk_quad_start: assert property (
		$past(rstn) && $past(rstn, 2) && $past(g0) == 3'h5
		&& $past(g0, 2) != 3'h5 |-> tx_symbol[0] == slbt_pkg::SYM_ZEROS)
		else $error("four-symbol pattern not started with zeros");
	chk_rx_raw: assert property (
		$past(rstn) && $past(rstn, 2) && !$past(a0) && !$past(a0, 2)
		|-> rx_word[0] == $past(rx_symbol[0], 2))
		else $error("unaligned receive data altered");
	chk_pm_off: assert property (
		$past(rstn) && ($past(m0) == 3'h0 || $past(m0) > 3'h4)
		|-> !pm_synced[0])
		else $error("matcher locked while off");
	chk_lock_wait: assert property (
		$rose(pm_synced[0]) |-> !$past(pm_synced[0], 7) && $past(m0) != 3'h0)
		else $error("matcher locked too soon");
	chk_count_hold: assert property (
		$past(rstn) && !$past(cnt_read[0]) && !$past(cnt_clear[0])
		|-> $stable(err_report[0]))
		else $error("count changed without read");
	chk_clear_zero: assert property (
		$past(rstn) && $past(cnt_clear[0]) |-> err_report[0] == '0)
		else $error("count not cleared");
	chk_scale_range: assert property (
		err_report[0].error_count_scaled_flag
		|-> err_report[0].count >= slbt_pkg::CNT_RESCALE)
		else $error("scaled count below range");
endmodule
bind slbt_bert_port slbt_bert_port_properties i_chk (.sys_clk, .rstn,
	.lane_cfg, .tx_traffic, .rx_symbol, .cnt_clear, .cnt_read,
	.tx_symbol, .rx_word, .pm_synced, .err_report);
`default_nettype wire

// [slbt_link_partner.sv]
// Link partner model: loops every lane's symbols back to the port.
// Assumes one symbol per lane per cycle; a flip request corrupts one.
`timescale 1ns/10ps
`default_nettype none
module slbt_link_partner
(
	input  wire logic            sys_clk,   // system clock
	input  wire logic [3:0][9:0] tx_symbol, // symbols from port
	input  wire logic [3:0]      err_flip,  // corrupt this one
	output var  logic [3:0][9:0] rx_symbol  // symbols to port
);
	always_ff @(posedge sys_clk)
		for (int i = 0; i < 4; i++)
			rx_symbol[i] <= tx_symbol[i] ^ {9'h000, err_flip[i]};
endmodule
`default_nettype wire

// [serial_lane_bit_error_tester_test.sv]
// Self-checking bench of the lane tester port with a loopback partner.
// Assumes a 100 MHz clock and the package's mode codes.
`timescale 1ns/10ps
`default_nettype none
module serial_lane_bit_error_tester_test;
	logic                           sys_clk = 1'b0;
	logic                           rstn = 1'b0;
	slbt_pkg::slbt_lane_cfg_s [3:0] lane_cfg = '0;
	logic [3:0][9:0]                tx_traffic = '0;
	logic [3:0][9:0]                rx_symbol;
	logic [3:0]                     cnt_clear = '0;
	logic [3:0]                     cnt_read = '0;
	logic [3:0]                     err_flip = '0;
	logic [3:0][9:0]                tx_symbol;
	logic [3:0][9:0]                rx_word;
	logic [3:0]                     pm_synced;
	slbt_pkg::slbt_err_s [3:0]      err_report;
	int                             n_fail = 0;
	int                             comparisons = 0;
	logic [14:0]                    st [4];
	int                             idx [4];
	logic [9:0]                     rot_pat;
	// Pairs of generator, matcher and expected lock
	int pairs [7] = '{12'h111, 12'h221, 12'h331, 12'h441, 12'h340,
		12'h100, 12'h450};

	always #5 sys_clk = ~sys_clk;

	slbt_bert_port i_dut (.sys_clk, .rstn, .lane_cfg, .tx_traffic,
		.rx_symbol, .cnt_clear, .cnt_read, .tx_symbol, .rx_word,
		.pm_synced, .err_report);
	slbt_link_partner i_partner (.sys_clk, .tx_symbol, .err_flip,
		.rx_symbol);

	task automatic fail(string s);
		n_fail++;
		$display("Error t=%0t %s", $time, s);
	endtask
	task automatic chk_val(logic [9:0] got, logic [9:0] exp);
		comparisons++;
		if (got !== exp)
			fail($sformatf("value %h expected %h", got, exp));
	endtask
	task automatic chk_bit(logic got, logic exp);
		comparisons++;
		if (got !== exp)
			fail($sformatf("flag %b expected %b", got, exp));
	endtask
	task automatic chk_err(slbt_pkg::slbt_err_s got,
		slbt_pkg::slbt_err_s exp);
		comparisons++;
		if (got !== exp)
			fail($sformatf("count %h expected %h", got, exp));
	endtask

	// Expected symbol; advances the lane's model state
	function automatic logic [9:0] gen_model(int l, logic [9:0] tr);
		logic [2:0]      m;
		logic [9:0]      p;
		logic [9:0]      s;
		logic [3:0][9:0] q;
		logic            fb;
		m = lane_cfg[l].gen_mode;
		p = lane_cfg[l].fixed_pattern_value;
		q = {slbt_pkg::SYM_ZEROS, p, slbt_pkg::SYM_ONES, ~p};
		s = tr;
		if (m == 3'h1 || m == 3'h2)
			for (int b = 9; b >= 0; b--)
			begin
				fb = m == 3'h1 ? st[l][14] ^ st[l][13] : st[l][6] ^ st[l][5];
				st[l] = {st[l][13:0], fb};
				s[b] = fb;
			end
		else if (m == 3'h3)
			s = p;
		else if (m == 3'h4)
			s = idx[l][0] ? ~p : p;
		else if (m == 3'h5)
			s = q[3 - idx[l] % 4];
		idx[l]++;
		return s;
	endfunction

	task automatic gen_test(int n);
		slbt_pkg::slbt_lane_cfg_s [3:0] nc;
		logic [3:0][9:0]                old;
		int                             ones;
		ones = 0;
		nc = lane_cfg;
		for (int l = 0; l < 4; l++)
		begin
			nc[l].gen_mode = 3'h0;
			st[l] = slbt_pkg::LFSR_SEED;
			idx[l] = 0;
		end
		@(posedge sys_clk);
		lane_cfg <= nc;
		for (int l = 0; l < 4; l++)
			nc[l] = 17'($urandom);
		if (n == 127)
			nc[0].gen_mode = 3'h2;
		@(posedge sys_clk);
		lane_cfg <= nc;
		tx_traffic <= 40'({$urandom, $urandom});
		repeat (n)
		begin
			@(posedge sys_clk);
			old = tx_traffic;
			tx_traffic <= 40'({$urandom, $urandom});
			#1;
			ones += $countones(tx_symbol[0]);
			for (int l = 0; l < 4; l++)
				chk_val(tx_symbol[l], gen_model(l, old[l]));
		end
		if (n == 127)
			chk_val(10'(ones), 10'h280);
		$display("generator test done, lane 0 mode %0d", nc[0].gen_mode);
	endtask

	task automatic rd(output slbt_pkg::slbt_err_s [3:0] r);
		@(posedge sys_clk);
		cnt_read <= 4'hF;
		@(posedge sys_clk);
		cnt_read <= 4'h0;
		#1;
		r = err_report;
	endtask

	task automatic pm_test(int pr);
		slbt_pkg::slbt_lane_cfg_s [3:0] nc;
		slbt_pkg::slbt_err_s [3:0]      r;
		int                             k;
		k = pr[11:8] > 2 ? $urandom_range(4, 1) : 0;
		for (int l = 0; l < 4; l++)
			nc[l] = {pr[10:8], pr[6:4], 10'($urandom), 1'b0};
		@(posedge sys_clk);
		lane_cfg <= nc;
		repeat (40) @(posedge sys_clk);
		#1;
		for (int l = 0; l < 4; l++)
			chk_bit(pm_synced[l], pr[0]);
		@(posedge sys_clk);
		cnt_clear <= 4'hF;
		@(posedge sys_clk);
		cnt_clear <= 4'h0;
		repeat (k)
		begin
			repeat (6) @(posedge sys_clk);
			err_flip <= 4'h1;
			@(posedge sys_clk);
			err_flip <= 4'h0;
		end
		repeat (12) @(posedge sys_clk);
		rd(r);
		for (int l = 0; l < 4; l++)
			chk_err(r[l], '0);
		rd(r);
		for (int l = 0; l < 4; l++)
			chk_err(r[l], {15'(l == 0 && pr[0] ? 2 * k : 0), 1'b0});
		$display("matcher test done, pair %h", pr);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		void'($urandom(32'hDFA082AD));
		repeat (11) @(posedge sys_clk);
		#1;
		for (int l = 0; l < 4; l++)
			chk_val(tx_symbol[l], '0);
		@(posedge sys_clk);
		rstn <= 1'b1;
		for (int t = 0; t < 12; t++)
			gen_test(t == 0 ? 127 : 12);
		for (int t = 0; t < 7; t++)
			pm_test(pairs[t]);
		// pattern off, then realign on rotated commas
		rot_pat = 10'({10'h0F8, 10'h0F8} >> $urandom_range(4, 0));
		@(posedge sys_clk);
		lane_cfg <= '0;
		tx_traffic[0] <= rot_pat;
		repeat (6) @(posedge sys_clk);
		#1;
		chk_val(rx_word[0], rot_pat);
		@(posedge sys_clk);
		lane_cfg[0].rx_align_en <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk_val(rx_word[0], 10'h0F8);
		$display("alignment test done");
		print_verdict();
	end

	// Tests need about 800 cycles
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		fail("watchdog expired");
		print_verdict();
	end
endmodule
`default_nettype wire
